// ===== hw/flash_charge_ctrl.sv
// charge sequencer for a flyback photoflash capacitor, with AXI4-Lite registers
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
module flash_charge_ctrl
  import charge_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic capacitor_fill_enable,
  input wire logic bias_supply_ok,
  input wire comp_s comp,
  input wire logic [1:0] current_limit_select,
  output logic switch_gate,
  output limit_e limit_level,
  output logic target_reached_out,
  output logic target_reached_oe_n,
  output logic standby,
  output logic irq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  chg_state_e state_reg;
  chg_state_e state_next;
  logic fill_prev_reg;
  logic supply_prev_reg;
  logic gate_reg;
  logic mode_fast_reg;
  logic mode_fast_next;
  limit_e limit_reg;
  logic done_out_reg;
  logic done_oe_n_reg;
  logic standby_reg;
  logic force_timer_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic irq_reg;
  logic [TMR_W-1:0] tmr_count;

  // bus slave state
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // sequencing decode
  wire fill_rise = capacitor_fill_enable & ~fill_prev_reg;
  // an edge seen while the supply is low is simply lost, so a held enable needs a new edge
  wire start_ok = fill_rise & bias_supply_ok;
  wire abort = ~capacitor_fill_enable | ~bias_supply_ok;
  wire on_expired = tmr_count >= ON_LAST;
  wire off_expired = tmr_count >= OFF_LAST;
  // switch node ringing right after turn-off is ignored until the least off-time passes
  wire blank_done = tmr_count >= OFF_MIN_CYC;
  wire sw_resume = ~force_timer_reg & blank_done & comp.sw_low;
  wire in_off = state_reg == ST_OFF;
  wire fb_stop = in_off & comp.fb_hit;
  wire cycle_start = state_next == ST_ON && state_reg != ST_ON;
  wire tmr_restart = state_next != state_reg;
  wire limit_e limit_pick = limit_e'(current_limit_select == PIN_GND ? LIM_1A0 :
                                     current_limit_select == PIN_SUPPLY ? LIM_1A4 : LIM_1A2);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start_ok) begin
          state_next = ST_ON;
        end
      end
      ST_ON: begin
        if (comp.current_limit_select_hit || on_expired) begin
          state_next = ST_OFF;
        end
      end
      ST_OFF: begin
        if (comp.fb_hit) begin
          state_next = ST_DONE;
        end else if (sw_resume || off_expired) begin
          state_next = ST_ON;
        end
      end
      ST_DONE: begin
        state_next = ST_DONE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (abort) begin
      state_next = ST_IDLE;
    end
  end

  always_comb begin
    mode_fast_next = mode_fast_reg;
    if (state_reg == ST_IDLE && start_ok) begin
      mode_fast_next = 1'b0;
    end else if (in_off && !abort && !comp.fb_hit && sw_resume) begin
      mode_fast_next = 1'b1;
    end
  end

  cycle_timer u_timer (
    .mclk(mclk),
    .nrst(nrst),
    .restart(tmr_restart),
    .count(tmr_count)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      fill_prev_reg <= 1'b0;
      supply_prev_reg <= 1'b0;
      gate_reg <= 1'b0;
      mode_fast_reg <= 1'b0;
      standby_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      fill_prev_reg <= capacitor_fill_enable;
      supply_prev_reg <= bias_supply_ok;
      gate_reg <= state_next == ST_ON;
      mode_fast_reg <= mode_fast_next;
      standby_reg <= ~capacitor_fill_enable;
    end
  end

  // the limit is sampled only as a cycle starts, so a pin change never cuts an on-time short
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      limit_reg <= LIM_1A0;
    end else if (cycle_start) begin
      limit_reg <= limit_pick;
    end
  end

  // open drain: value held low, only the enable moves
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      done_out_reg <= 1'b0;
      done_oe_n_reg <= 1'b1;
    end else begin
      done_out_reg <= 1'b0;
      done_oe_n_reg <= state_next != ST_DONE;
    end
  end

  // interrupt events
  irq_s ev;
  assign ev.done = fb_stop & ~abort;
  assign ev.started = state_reg == ST_IDLE && start_ok;
  assign ev.supply_lost = supply_prev_reg & ~bias_supply_ok;
  assign ev.fast_entered = ~mode_fast_reg & mode_fast_next;

  // bus decode
  wire aw_take = s_axi_awvalid & awready_reg;
  wire w_take = s_axi_wvalid & wready_reg;
  wire ar_take = s_axi_arvalid & arready_reg;
  wire wr_fire = ~awready_reg & ~wready_reg & ~bvalid_reg;
  wire wr_lane = wr_fire & wstrb0_reg;
  wire wr_ctrl = wr_lane && aw_addr_reg == OFF_CTRL;
  wire wr_en = wr_lane && aw_addr_reg == OFF_IRQ_EN;
  wire wr_clr = wr_lane && aw_addr_reg == OFF_IRQ_CLR;
  wire wr_known = aw_addr_reg == OFF_CTRL || aw_addr_reg == OFF_STATUS || aw_addr_reg == OFF_IRQ_STAT ||
                  aw_addr_reg == OFF_IRQ_EN || aw_addr_reg == OFF_IRQ_CLR;
  wire [ADDR_W-1:0] rd_addr = {s_axi_araddr[ADDR_W-1:2], 2'h0};
  wire rd_known = rd_addr == OFF_CTRL || rd_addr == OFF_STATUS || rd_addr == OFF_IRQ_STAT ||
                  rd_addr == OFF_IRQ_EN || rd_addr == OFF_IRQ_CLR;
  wire [IRQ_W-1:0] irq_clr_vec = wr_clr ? wdata_reg[IRQ_W-1:0] : '0;
  status_s stat;
  assign stat = '{zero: '0, done: state_reg == ST_DONE, supply_ok: bias_supply_ok,
                  limit: limit_reg, fast: mode_fast_reg, state: state_reg};
  wire [31:0] rd_word = rd_addr == OFF_CTRL ? {31'h0, force_timer_reg} :
                        rd_addr == OFF_STATUS ? stat :
                        rd_addr == OFF_IRQ_STAT ? {28'h0, irq_stat_reg} :
                        rd_addr == OFF_IRQ_EN ? {28'h0, irq_en_reg} : 32'h0;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      force_timer_reg <= CTRL_FORCE_TIMER_RST;
      irq_en_reg <= IRQ_EN_RST;
      irq_stat_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        force_timer_reg <= wdata_reg[CTRL_FORCE_TIMER_BIT];
      end
      if (wr_en) begin
        irq_en_reg <= wdata_reg[IRQ_W-1:0];
      end
      // a new event wins over a clear in the same cycle
      irq_stat_reg <= (irq_stat_reg & ~irq_clr_vec) | ev;
      irq_reg <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // write channel: address and data in either order, response one cycle after both
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aw_addr_reg <= '0;
      wdata_reg <= 8'h0;
      wstrb0_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_reg <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
        awready_reg <= 1'b0;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
        wready_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // read channel: data registered at the address handshake
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign switch_gate = gate_reg;
  assign limit_level = limit_reg;
  assign target_reached_out = done_out_reg;
  assign target_reached_oe_n = done_oe_n_reg;
  assign standby = standby_reg;
  assign irq = irq_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  wire run = capacitor_fill_enable & bias_supply_ok;

  AST_START_EDGE: assert property (
    $rose(state_reg == ST_ON) && $past(state_reg) == ST_IDLE |-> $past(start_ok))
    else $error("session began without an enable edge under good supply");
  AST_NO_LEVEL_START: assert property (
    state_reg == ST_IDLE && capacitor_fill_enable && fill_prev_reg |=> state_reg == ST_IDLE)
    else $error("held enable started a session");
  AST_FB_STOP: assert property (
    in_off && comp.fb_hit && run |=> state_reg == ST_DONE && !switch_gate)
    else $error("feedback threshold did not stop charging");
  AST_DONE_HOLD: assert property (
    state_reg == ST_DONE && run |=> state_reg == ST_DONE && !switch_gate)
    else $error("charging restarted without a new edge");
  AST_DONE_PIN: assert property (
    $rose(state_reg == ST_DONE) |-> !target_reached_oe_n && !target_reached_out)
    else $error("completion pin not pulled low");
  AST_RECHARGE: assert property (
    state_reg == ST_IDLE && start_ok |=> switch_gate && target_reached_oe_n)
    else $error("new edge did not restart charging");
  AST_STANDBY: assert property (
    !capacitor_fill_enable |=> state_reg == ST_IDLE && !switch_gate && standby)
    else $error("enable low did not force standby");
  AST_CURRENT_LIMIT_SELECT_OFF: assert property (
    state_reg == ST_ON && comp.current_limit_select_hit |=> !switch_gate)
    else $error("switch stayed on past current limit");
  AST_FB_IN_OFF: assert property (
    $rose(state_reg == ST_DONE) |-> $past(state_reg) == ST_OFF && !$past(gate_reg))
    else $error("completion decided outside an off-time");
  AST_FAST_RESUME: assert property (
    in_off && !comp.fb_hit && sw_resume && run |=> switch_gate && mode_fast_reg)
    else $error("low switch node did not restart the cycle");
  AST_OFF_CAP: assert property (
    in_off |-> tmr_count <= OFF_LAST)
    else $error("off-time ran past its maximum");
  AST_OFF_EXPIRE: assert property (
    in_off && tmr_count == OFF_LAST && !comp.fb_hit && run |=> switch_gate)
    else $error("timer expiry did not turn the switch on");
  AST_TIMER_FIRST: assert property (
    state_reg == ST_IDLE && start_ok |=> !mode_fast_reg)
    else $error("session did not open in timer mode");
  AST_LIMIT_MAP: assert property (
    $rose(switch_gate) |-> limit_reg == $past(limit_pick))
    else $error("limit not taken from pin at cycle start");
  AST_LIMIT_STEADY: assert property (
    switch_gate && $past(switch_gate) |-> $stable(limit_reg))
    else $error("limit changed within an on-time");
  AST_RELEASE: assert property (
    !capacitor_fill_enable |=> target_reached_oe_n && !target_reached_out)
    else $error("completion pin not released");

  COV_DONE: cover property (state_reg == ST_OFF ##1 state_reg == ST_DONE);
  COV_FAST: cover property (ev.fast_entered);
  COV_TIMER: cover property (in_off && off_expired && run && !comp.fb_hit);
  COV_IRQ: cover property ($rose(irq));
endmodule

// ===== shared/charge_ctrl_pkg.sv
// shared constants, types and register map of the capacitor charge sequencer
package charge_ctrl_pkg;
  // clock and switching times
  localparam int CLK_MHZ = 200;
  localparam int OFF_MAX_NS = 18000;
  localparam int ON_MAX_NS = 18000;
  localparam int OFF_MIN_NS = 300;
  localparam int TMR_W = 12;
  // longest times round down, least time rounds up
  localparam logic [TMR_W-1:0] OFF_LAST = TMR_W'(OFF_MAX_NS * CLK_MHZ / 1000 - 1);
  localparam logic [TMR_W-1:0] ON_LAST = TMR_W'(ON_MAX_NS * CLK_MHZ / 1000 - 1);
  localparam logic [TMR_W-1:0] OFF_MIN_CYC = TMR_W'((OFF_MIN_NS * CLK_MHZ + 999) / 1000);

  // register map, byte addresses
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 5'h10;
  localparam int CTRL_FORCE_TIMER_BIT = 0;
  localparam logic CTRL_FORCE_TIMER_RST = 1'h0;
  localparam int IRQ_W = 4;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // current limit pin sense codes
  localparam logic [1:0] PIN_GND = 2'h0;
  localparam logic [1:0] PIN_FLOAT = 2'h1;
  localparam logic [1:0] PIN_SUPPLY = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ON = 4'h2,
    ST_OFF = 4'h4,
    ST_DONE = 4'h8
  } chg_state_e;

  typedef enum logic [1:0] {
    LIM_1A0 = 2'h0,
    LIM_1A2 = 2'h1,
    LIM_1A4 = 2'h2
  } limit_e;

  typedef struct packed {
    logic current_limit_select_hit;
    logic sw_low;
    logic fb_hit;
  } comp_s;

  typedef struct packed {
    logic fast_entered;
    logic supply_lost;
    logic started;
    logic done;
  } irq_s;

  typedef struct packed {
    logic [22:0] zero;
    logic done;
    logic supply_ok;
    limit_e limit;
    logic fast;
    chg_state_e state;
  } status_s;
endpackage

// ===== hw/cycle_timer.sv
// saturating cycle counter that times the switch on and off intervals
module cycle_timer
  import charge_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic restart,
  output logic [TMR_W-1:0] count
);
  logic [TMR_W-1:0] count_reg;

  // saturates so a stalled interval never wraps into a false short count
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
    end else if (restart) begin
      count_reg <= '0;
    end else if (count_reg != '1) begin
      count_reg <= count_reg + TMR_W'(1);
    end
  end

  assign count = count_reg;

  AST_TMR_RESTART: assert property (@(posedge mclk) disable iff (!nrst)
    restart |=> count_reg == '0 ##1 count_reg == TMR_W'(1) || $past(restart))
    else $error("timer did not restart from zero");
endmodule

// ===== tb/flyback_stage_model.sv
// behavioural flyback power stage feeding the sequencer comparators
module flyback_stage_model
  import charge_ctrl_pkg::*;
#(
  parameter int FAST_V = 3,
  parameter int TARGET_V = 5
)
(
  input wire logic mclk,
  input wire logic switch_gate,
  input wire limit_e limit_level,
  input wire logic discharge,
  input wire logic fb_glitch,
  output comp_s comp
);
  timeunit 1ns;
  timeprecision 1ps;
  int on_cnt = 0;
  int off_cnt = 0;
  int vout = 0;
  // each completed on-time pushes one step of charge into the output
  always @(posedge mclk) begin
    on_cnt <= switch_gate ? on_cnt + 1 : 0;
    off_cnt <= switch_gate ? 0 : off_cnt + 1;
    if (discharge)
      vout <= 0;
    else if (!switch_gate && on_cnt != 0)
      vout <= vout + 1;
  end
  // a higher limit takes longer to ramp up
  assign comp.current_limit_select_hit = switch_gate && on_cnt >= 4 + 2 * int'(limit_level);
  // node sits low while on; rings low in off-time only once the output has built up
  assign comp.sw_low = switch_gate || (vout >= FAST_V && off_cnt >= 70);
  // divider reads garbage while on, so the glitch stands for noise there
  assign comp.fb_hit = switch_gate ? fb_glitch : vout >= TARGET_V;
endmodule

// ===== tb/flash_capacitor_charge_ctrl_bench.sv
// self-checking bench for the flash capacitor charge sequencer
module flash_capacitor_charge_ctrl_bench
  import charge_ctrl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0;
  logic nrst = 1'h0;
  logic fill_en = 1'h0;
  logic supply_ok = 1'h1;
  logic [1:0] lim_sel = PIN_GND;
  logic discharge = 1'h0;
  logic fb_glitch = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic switch_gate, done_out, done_oe_n, standby, irq;
  logic hit_d = 1'h0, oe_d = 1'h1;
  comp_s comp;
  limit_e limit_level;
  int errors = 0;
  int n_tests = 0;

  flash_charge_ctrl dut (
    .mclk, .nrst, .capacitor_fill_enable(fill_en), .bias_supply_ok(supply_ok), .comp,
    .current_limit_select(lim_sel), .switch_gate, .limit_level, .target_reached_out(done_out),
    .target_reached_oe_n(done_oe_n), .standby, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  flyback_stage_model stage (.mclk, .switch_gate, .limit_level, .discharge, .fb_glitch, .comp);

  initial forever #2.5 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d, checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // sampled on the falling edge so every registered output has settled
  always @(negedge mclk) begin
    if (hit_d) chk(switch_gate, 1'h0);
    if (oe_d && !done_oe_n) chk(switch_gate, 1'h0);
    if (!done_oe_n) chk(done_out, 1'h0);
    hit_d = comp.current_limit_select_hit & switch_gate;
    oe_d = done_oe_n;
  end

  // the full run needs about 29k cycles; this leaves ample margin
  initial begin
    #250000;
    errors++;
    print_verdict();
  end

  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] rexp);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, rexp);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [1:0] rexp);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rresp, rexp);
    if (rexp === RESP_OKAY) chk(s_axi_rdata, exp);
  endtask

  // length of the next off-time in cycles; stops early if completion is flagged
  task automatic off_len(output int n);
    n = 0;
    while (switch_gate && n < 100) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    while (!switch_gate && done_oe_n && n < 5000) begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic t_undervoltage_lockout();
    @(posedge mclk);
    supply_ok <= 1'h0;
    @(posedge mclk);
    fill_en <= 1'h1;
    repeat (20) @(negedge mclk);
    chk(switch_gate, 1'h0);
    @(posedge mclk);
    supply_ok <= 1'h1;
    repeat (20) @(negedge mclk);
    chk(switch_gate, 1'h0);
    @(posedge mclk);
    fill_en <= 1'h0;
    @(posedge mclk);
    fill_en <= 1'h1;
    repeat (3) @(negedge mclk);
    chk(switch_gate, 1'h1);
    @(posedge mclk);
    fill_en <= 1'h0;
    repeat (2) @(negedge mclk);
    chk({switch_gate, standby}, 2'h1);
  endtask

  // slow: force_timer is set, so the third off-time must also run to the timer
  task automatic session(input logic [1:0] sel, input limit_e lim, input logic mid, input logic slow);
    int n;
    @(posedge mclk);
    lim_sel <= sel;
    discharge <= 1'h1;
    @(posedge mclk);
    discharge <= 1'h0;
    fill_en <= 1'h1;
    n = 0;
    while (!switch_gate && n < 50) begin
      @(negedge mclk);
      n++;
    end
    chk({limit_level, done_oe_n}, {lim, 1'h1});
    for (int i = 0; i < 2; i++) begin
      off_len(n);
      chk(n, OFF_LAST + 1);
      @(posedge mclk);
      if (mid) lim_sel <= PIN_FLOAT;
    end
    chk({limit_level, done_oe_n}, {mid ? LIM_1A2 : lim, 1'h1});
    off_len(n);
    if (slow) chk(n, OFF_LAST + 1);
    else chk(n > OFF_MIN_CYC && n <= OFF_LAST, 1'h1);
    n = 0;
    while (done_oe_n && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    chk({switch_gate, done_oe_n}, 2'h0);
    repeat (50) @(negedge mclk);
    chk({switch_gate, done_oe_n}, 2'h0);
    @(posedge mclk);
    fill_en <= 1'h0;
    repeat (2) @(negedge mclk);
    chk({done_oe_n, standby}, 2'h3);
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'h1;
    @(negedge mclk);
    chk({switch_gate, done_oe_n, done_out, standby, irq}, 5'h0a);
    rd_chk(OFF_CTRL, 32'h0, RESP_OKAY);
    rd_chk(OFF_IRQ_EN, 32'h0, RESP_OKAY);
    rd_chk(5'h14, 32'h0, RESP_SLVERR);
    axi_wr(5'h18, 32'h0, RESP_SLVERR);
    t_undervoltage_lockout();
    session(PIN_GND, LIM_1A0, 1'h0, 1'h0);
    // every event has fired by now but none is enabled yet
    @(negedge mclk);
    chk(irq, 1'h0);
    rd_chk(OFF_IRQ_STAT, 32'hf, RESP_OKAY);
    axi_wr(OFF_IRQ_EN, 32'h1, RESP_OKAY);
    repeat (3) @(negedge mclk);
    chk(irq, 1'h1);
    axi_wr(OFF_IRQ_CLR, 32'hf, RESP_OKAY);
    repeat (3) @(negedge mclk);
    chk(irq, 1'h0);
    rd_chk(OFF_IRQ_STAT, 32'h0, RESP_OKAY);
    rd_chk(OFF_IRQ_EN, 32'h1, RESP_OKAY);
    @(posedge mclk);
    fb_glitch <= 1'h1;
    session(PIN_SUPPLY, LIM_1A4, 1'h1, 1'h0);
    axi_wr(OFF_CTRL, 32'h1, RESP_OKAY);
    rd_chk(OFF_CTRL, 32'h1, RESP_OKAY);
    session(PIN_FLOAT, LIM_1A2, 1'h0, 1'h1);
    rd_chk(OFF_STATUS, {23'h0, 1'h0, 1'h1, LIM_1A2, 1'h0, ST_IDLE}, RESP_OKAY);
    print_verdict();
  end
endmodule
